// File: verilog/health_pkg.sv
// Purpose: Shared constants and carriers for the sensor health status word
// Assumes: 100 MHz system clock
// Notes:   Bit positions follow the status word layouts of both variants
package health_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned SETTLE_S        = 10;
  localparam int unsigned SETTLE_CYCLES   = SETTLE_S * CLK_HZ;
  localparam int unsigned DEV_PCT         = 10;
  localparam int unsigned PCT_FULL        = 100;
  localparam int unsigned BAD_INTERVALS   = 3;

  // Full variant layout
  localparam int unsigned FULL_W          = 32;
  localparam int unsigned FULL_SPEED_BIT  = 21;
  localparam int unsigned FULL_CO2A_BIT   = 12;
  localparam int unsigned FULL_PART_BIT   = 11;
  localparam int unsigned FULL_FORMALDEHYDE_FAULT_BIT   = 10;
  localparam int unsigned FULL_CO2B_BIT   = 9;
  localparam int unsigned FULL_GAS_BIT    = 7;
  localparam int unsigned FULL_HT_BIT     = 6;
  localparam int unsigned FULL_FAN_BIT    = 4;

  // Particulate-only variant layout
  localparam int unsigned SHORT_W         = 16;
  localparam int unsigned SHORT_FAN_BIT   = 4;
  localparam int unsigned SHORT_SPEED_BIT = 1;

  localparam logic [31:0] FULL_RESET      = 32'h0000_0000;
  localparam logic [15:0] SHORT_RESET     = 16'h0000;

  // Fault reports from the subsystems
  typedef struct packed {
    logic carbon_dioxide_fault_a;
    logic particle_fault;
    logic formaldehyde_fault;
    logic carbon_dioxide_fault_b;
    logic gas_fault;
    logic humidity_temp_fault;
    logic blower_fault;
  } fault_s;

  // Host-side status commands
  typedef struct packed {
    logic read_clear;
    logic device_reset;
  } status_cmd_s;

  typedef enum logic [1:0] {
    MODE_IDLE    = 2'b01,
    MODE_MEASURE = 2'b10
  } mode_e;

endpackage

// File: verilog/settle_timer.sv
// Purpose: Holds off fan checking for the settling period after measurement start
// Assumes: run is high throughout measurement mode
// Notes:   Restarts each time run rises
`timescale 1ns/1ps
module settle_timer
  import health_pkg::*;
#(
  parameter int unsigned CYCLES = SETTLE_CYCLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Control
  input  wire logic run,
  output logic      settled
);

  typedef struct packed {
    logic [31:0] count;
    logic        done;
  } state_s;

  state_s st;
  state_s next_st;

  always_comb begin
    next_st = st;
    if (!run) begin
      next_st.count = 32'h0;
      next_st.done  = 1'b0;
    end else if (!st.done) begin
      if (st.count >= CYCLES - 1) begin
        next_st.done = 1'b1;
      end else begin
        next_st.count = st.count + 32'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign settled = st.done;

endmodule

// File: verilog/speed_monitor.sv
// Purpose: Judges fan speed against target once per measurement interval
// Assumes: interval_tick is a one-cycle pulse, speeds are sampled on it
// Notes:   Several bad intervals in a row raise the warning, one good one drops it
`timescale 1ns/1ps
module speed_monitor
  import health_pkg::*;
#(
  parameter int unsigned SPD_W   = 16,
  parameter int unsigned BAD_RUN = BAD_INTERVALS
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Qualifiers
  input  wire logic             enable,
  input  wire logic             interval_tick,
  // Speeds
  input  wire logic [SPD_W-1:0] target_speed,
  input  wire logic [SPD_W-1:0] measured_speed,
  output logic                  warning
);

  typedef struct packed {
    logic [7:0] bad_count;
    logic       warn;
  } state_s;

  state_s st;
  state_s next_st;

  // Off by more than the allowed percentage, done in widened arithmetic
  function automatic logic off_target(input logic [SPD_W-1:0] tgt, input logic [SPD_W-1:0] meas);
    logic [SPD_W+7:0] diff;
    logic [SPD_W+7:0] lhs;
    logic [SPD_W+7:0] rhs;
    diff = (meas > tgt) ? {8'h0, meas - tgt} : {8'h0, tgt - meas};
    lhs  = diff * (SPD_W+8)'(PCT_FULL);
    rhs  = {8'h0, tgt} * (SPD_W+8)'(DEV_PCT);
    return lhs > rhs;
  endfunction

  always_comb begin
    next_st = st;
    if (!enable) begin
      next_st = '0;
    end else if (interval_tick) begin
      if (off_target(target_speed, measured_speed)) begin
        if (st.bad_count < 8'(BAD_RUN)) begin
          next_st.bad_count = st.bad_count + 8'h1;
        end
        if (st.bad_count + 8'h1 >= 8'(BAD_RUN)) begin
          next_st.warn = 1'b1;
        end
      end else begin
        next_st.bad_count = 8'h0;
        next_st.warn      = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign warning = st.warn;

endmodule

// File: verilog/sensor_health_status.sv
// Purpose: Sensor health status word with sticky faults and live fan-speed warning
// Assumes: Command strobes come from the serial command decoder on CLK
// Notes:   Both variant words are produced; the host reads the one for its part
//
// Overview of operation
// - Full word: bit 21 speed, seven error bits
// - Short word: bit 4 blower, bit 1 speed
// - Warn when fan off target over intervals
// - No speed check for 10 s settling
// - Warning clears when speed good or idle
// - Warning reads 1 bad, 0 acceptable
// - Bit 12 flags carbon dioxide sensor A
// - Error flags stick after fault and mode exit
// - Clear only by read-clear, device reset, power
// - Carbon dioxide flag set only while measuring
// - Reset enters idle, fan and laser off
// - Bit 11 sticky particle fault, measuring only
`timescale 1ns/1ps
module sensor_health_status
  import health_pkg::*;
#(
  parameter int unsigned SPD_W         = 16,
  parameter int unsigned SETTLE_CNT    = SETTLE_CYCLES,
  parameter int unsigned BAD_RUN       = BAD_INTERVALS
) (
  // Clock and reset
  input  wire logic               CLK,
  input  wire logic               SYS_RST,
  // Mode commands
  input  wire logic               START_MEASURE,
  input  wire logic               STOP_MEASURE,
  // Status commands
  input  wire status_cmd_s        STATUS_CMD,
  // Subsystem fault reports
  input  wire fault_s             FAULTS,
  // Fan speed
  input  wire logic               INTERVAL_TICK,
  input  wire logic [SPD_W-1:0]   TARGET_SPEED,
  input  wire logic [SPD_W-1:0]   MEASURED_SPEED,
  // Mode state
  output logic                    MEASURING,
  output logic                    FAN_ON,
  output logic                    LASER_ON,
  // Status words
  output logic [FULL_W-1:0]       STATUS_FULL,
  output logic [SHORT_W-1:0]      STATUS_SHORT,
  // Snapshot returned by read-clear
  output logic [FULL_W-1:0]       READ_FULL,
  output logic [SHORT_W-1:0]      READ_SHORT,
  output logic                    READ_VALID
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    mode_e               mode;
    fault_s              sticky;
    logic [FULL_W-1:0]   read_full;
    logic [SHORT_W-1:0]  read_short;
    logic                read_valid;
  } state_s;

  state_s st;
  state_s next_st;

  logic settled;
  logic speed_warn;
  logic measuring;

  assign measuring = (st.mode == MODE_MEASURE);

  ////////////////////////////////////////////////////////////////////////////
  // Fan speed checking

  settle_timer #(
    .CYCLES (SETTLE_CNT)
  ) u_settle (
    .clk     (CLK),
    .rst     (SYS_RST),
    .run     (measuring),
    .settled (settled)
  );

  speed_monitor #(
    .SPD_W   (SPD_W),
    .BAD_RUN (BAD_RUN)
  ) u_speed (
    .clk            (CLK),
    .rst            (SYS_RST),
    .enable         (measuring && settled),
    .interval_tick  (INTERVAL_TICK),
    .target_speed   (TARGET_SPEED),
    .measured_speed (MEASURED_SPEED),
    .warning        (speed_warn)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Word packing; unlisted positions stay zero

  function automatic logic [FULL_W-1:0] pack_full(input fault_s f, input logic warn);
    logic [FULL_W-1:0] w;
    w                 = FULL_RESET;
    w[FULL_SPEED_BIT] = warn;
    w[FULL_CO2A_BIT]  = f.carbon_dioxide_fault_a;
    w[FULL_PART_BIT]  = f.particle_fault;
    w[FULL_FORMALDEHYDE_FAULT_BIT]  = f.formaldehyde_fault;
    w[FULL_CO2B_BIT]  = f.carbon_dioxide_fault_b;
    w[FULL_GAS_BIT]   = f.gas_fault;
    w[FULL_HT_BIT]    = f.humidity_temp_fault;
    w[FULL_FAN_BIT]   = f.blower_fault;
    return w;
  endfunction

  function automatic logic [SHORT_W-1:0] pack_short(input fault_s f, input logic warn);
    logic [SHORT_W-1:0] w;
    w                  = SHORT_RESET;
    w[SHORT_FAN_BIT]   = f.blower_fault;
    w[SHORT_SPEED_BIT] = warn;
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_st            = st;
    next_st.read_valid = 1'b0;

    // Mode control; device reset and stop both return to idle
    if (STATUS_CMD.device_reset || STOP_MEASURE) begin
      next_st.mode = MODE_IDLE;
    end else if (START_MEASURE) begin
      next_st.mode = MODE_MEASURE;
    end

    // Read-clear returns the word as it stood, then clears the sticky fault flags; the speed warning stays live
    if (STATUS_CMD.read_clear) begin
      next_st.read_full  = pack_full(st.sticky, speed_warn);
      next_st.read_short = pack_short(st.sticky, speed_warn);
      next_st.read_valid = 1'b1;
    end
    if (STATUS_CMD.read_clear || STATUS_CMD.device_reset) begin
      next_st.sticky = '0;
    end

    // Faults only latch while measuring; an arrival on the clear cycle wins
    if (measuring) begin
      next_st.sticky = next_st.sticky | FAULTS;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      st            <= '0;
      st.mode       <= MODE_IDLE;
      st.read_full  <= FULL_RESET;
      st.read_short <= SHORT_RESET;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign MEASURING    = measuring;
  assign FAN_ON       = measuring;
  assign LASER_ON     = measuring;
  assign STATUS_FULL  = pack_full(st.sticky, speed_warn);
  assign STATUS_SHORT = pack_short(st.sticky, speed_warn);
  assign READ_FULL    = st.read_full;
  assign READ_SHORT   = st.read_short;
  assign READ_VALID   = st.read_valid;

endmodule

// File: dv/health_sva.sv
// Purpose: Port checks for the sensor health status word
// Assumes: Bound to sensor_health_status, one clock domain
// Notes:   Speed warning timing checked loosely, settling window fixed
`timescale 1ns/1ps
module health_sva
  import health_pkg::*;
(
  // Clock, reset and inputs
  input wire logic                CLK,
  input wire logic                SYS_RST,
  input wire logic                START_MEASURE,
  input wire logic                STOP_MEASURE,
  input wire status_cmd_s         STATUS_CMD,
  input wire fault_s              FAULTS,
  input wire logic                INTERVAL_TICK,
  // Outputs
  input wire logic                MEASURING,
  input wire logic                FAN_ON,
  input wire logic                LASER_ON,
  input wire logic [FULL_W-1:0]   STATUS_FULL,
  input wire logic [SHORT_W-1:0]  STATUS_SHORT,
  input wire logic [FULL_W-1:0]   READ_FULL,
  input wire logic                READ_VALID
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  ////////////////////////////////////////
  property p_resv;
    (STATUS_FULL & ~32'h0020_1ed0) == 32'h0 && (STATUS_SHORT & ~16'h0012) == 16'h0;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bit set");
  property p_short;
    STATUS_SHORT[1] == STATUS_FULL[21] && STATUS_SHORT[4] == STATUS_FULL[4];
  endproperty
  a_short: assert property (p_short) else $error("short word mismatch");
  property p_mode;
    FAN_ON == MEASURING && LASER_ON == MEASURING;
  endproperty
  a_mode: assert property (p_mode) else $error("fan or laser wrong");
  property p_start;
    START_MEASURE && !STOP_MEASURE && !STATUS_CMD.device_reset |=> MEASURING;
  endproperty
  a_start: assert property (p_start) else $error("start ignored");
  property p_idle;
    $rose(STATUS_FULL[12]) |-> $past(MEASURING);
  endproperty
  a_idle: assert property (p_idle) else $error("flag set in idle");
  property p_set;
    MEASURING && FAULTS.particle_fault && !STATUS_CMD.device_reset |=> STATUS_FULL[11];
  endproperty
  a_set: assert property (p_set) else $error("particle flag not set");
  property p_stick;
    STATUS_FULL[12] && !STATUS_CMD.read_clear && !STATUS_CMD.device_reset |=> STATUS_FULL[12];
  endproperty
  a_stick: assert property (p_stick) else $error("flag lost");
  property p_read;
    STATUS_CMD.read_clear |=> READ_VALID && READ_FULL == $past(STATUS_FULL);
  endproperty
  a_read: assert property (p_read) else $error("bad snapshot");
  property p_clear;
    STATUS_CMD.read_clear && !MEASURING |=> (STATUS_FULL & 32'h0000_1ed0) == 32'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("flags not cleared");
  property p_settle;
    $rose(MEASURING) |-> !STATUS_FULL[21] [*8];
  endproperty
  a_settle: assert property (p_settle) else $error("warning while settling");
  property p_warn_idle;
    !MEASURING [*2] |-> !STATUS_FULL[21];
  endproperty
  a_warn_idle: assert property (p_warn_idle) else $error("warning in idle");
  property p_warn_rise;
    $rose(STATUS_FULL[21]) |-> $past(INTERVAL_TICK);
  endproperty
  a_warn_rise: assert property (p_warn_rise) else $error("warning without tick");
  c_warn: cover property ($rose(STATUS_FULL[21]));
  c_read: cover property (READ_VALID && READ_FULL[11]);
  c_dres: cover property (STATUS_CMD.device_reset && MEASURING);
endmodule

bind sensor_health_status health_sva i_chk (.CLK(CLK), .SYS_RST(SYS_RST), .START_MEASURE(START_MEASURE),
  .STOP_MEASURE(STOP_MEASURE), .STATUS_CMD(STATUS_CMD), .FAULTS(FAULTS), .INTERVAL_TICK(INTERVAL_TICK),
  .MEASURING(MEASURING), .FAN_ON(FAN_ON), .LASER_ON(LASER_ON), .STATUS_FULL(STATUS_FULL),
  .STATUS_SHORT(STATUS_SHORT), .READ_FULL(READ_FULL), .READ_VALID(READ_VALID));

// File: dv/host_model.sv
// Purpose: Host controller issuing mode and status commands
// Assumes: Commands change on the falling edge
// Notes:   Holds the last set value, so a pulse needs an explicit clear
`timescale 1ns/1ps
module host_model
  import health_pkg::*;
(
  // Clock
  input wire logic    clk,
  // Commands
  output logic        start,
  output logic        stop,
  output status_cmd_s cmd
);
  initial {start, stop, cmd} = 4'h0;
  // Order: device reset, read-clear, stop, start
  task automatic send(input logic [3:0] r);
    @(negedge clk);
    {cmd.device_reset, cmd.read_clear, stop, start} = r;
  endtask
endmodule

// File: dv/tb_sensor_health_status_word.sv
// Purpose: Self-checking bench for the health status word
// Assumes: Settling shortened to 20 cycles, three bad ticks raise the warning
// Notes:   Model covers sticky flags, mode, snapshots and the speed warning
`timescale 1ns/1ps
module tb_sensor_health_status_word;
  import health_pkg::*;
  localparam int SETTLE = 20;
  logic        clk = 1'b0;
  logic        sys_rst;
  logic        tick;
  logic        start, stop, meas, fan, laser, rvalid;
  logic [15:0] spd, tgt, step;
  logic [15:0] shrt, rshrt;
  logic [31:0] full, rfull, r;
  status_cmd_s cmd;
  fault_s      flt;
  int          bad_count = 0, comparisons = 0, m_meas = 0, m_stk = 0, m_rd = 0, m_rv = 0;
  int          m_settle = 0, m_bad = 0, m_warn = 0;
  always #5 clk = ~clk;
  host_model i_host (.clk(clk), .start(start), .stop(stop), .cmd(cmd));
  sensor_health_status #(.SETTLE_CNT(SETTLE)) i_dut (.CLK(clk), .SYS_RST(sys_rst), .START_MEASURE(start),
    .STOP_MEASURE(stop), .STATUS_CMD(cmd), .FAULTS(flt), .INTERVAL_TICK(tick), .TARGET_SPEED(tgt),
    .MEASURED_SPEED(spd), .MEASURING(meas), .FAN_ON(fan), .LASER_ON(laser), .STATUS_FULL(full),
    .STATUS_SHORT(shrt), .READ_FULL(rfull), .READ_SHORT(rshrt), .READ_VALID(rvalid));
  ////////////////////////////////////////
  function automatic int map(fault_s f);
    return (int'(f[6:3]) << 9) | (int'(f[2:1]) << 6) | (int'(f[0]) << 4);
  endfunction
  always @(posedge clk) begin
    m_rv <= !sys_rst && cmd.read_clear;
    if (cmd.read_clear)
      m_rd <= m_stk | (m_warn << FULL_SPEED_BIT);
    if (sys_rst || cmd.device_reset) begin
      m_meas <= 0;
      m_stk <= 0;
    end else begin
      m_stk <= (cmd.read_clear ? 0 : m_stk) | (m_meas != 0 ? map(flt) : 0);
      m_meas <= stop ? 0 : (start ? 1 : m_meas);
    end
  end
  // Warning model: no judging until SETTLE measuring cycles have passed
  function automatic bit off(input int m, input int t);
    return (m > t ? m - t : t - m) * PCT_FULL > t * DEV_PCT;
  endfunction
  always @(posedge clk) begin
    m_settle <= (sys_rst || m_meas == 0) ? 0 : (m_settle < SETTLE ? m_settle + 1 : m_settle);
    if (sys_rst || m_meas == 0 || m_settle < SETTLE) begin
      m_bad <= 0;
      m_warn <= 0;
    end else if (tick) begin
      m_bad <= off(spd, tgt) ? m_bad + 1 : 0;
      m_warn <= off(spd, tgt) && m_bad + 1 >= BAD_INTERVALS;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  always @(negedge clk) begin
    if (!sys_rst) begin
      chk(full, m_stk | (m_warn << FULL_SPEED_BIT));
      chk(shrt, {11'h0, m_stk[4], 2'h0, m_warn[0], 1'b0});
      chk({laser, fan, meas}, {3{m_meas[0]}});
      chk(rvalid, m_rv);
      if (rvalid) begin
        chk(rfull, m_rd);
        chk(rshrt, {11'h0, m_rd[4], 2'h0, m_rd[FULL_SPEED_BIT], 1'b0});
      end
    end
  end
  // Speed-sample ticks, in band or off target, spaced so the registered warning has settled before checks
  task automatic tk(input logic [15:0] m);
    @(negedge clk);
    spd = m;
    tick = 1'b1;
    @(negedge clk);
    tick = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic stop_test;
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    stop_test();
  end
  ////////////////////////////////////////
  initial begin
    sys_rst = 1'b1;
    tick = 1'b0;
    spd = 16'h0;
    flt = '0;
    void'($urandom(32'hc3db6bb8));
    // Random target; probe speeds sit just inside and just outside the band
    tgt = 16'h0064 + 16'($urandom % 32'h0f00);
    step = tgt / 16'h000a;
    repeat (2) @(posedge clk);
    @(negedge clk) sys_rst = 1'b0;
    flt = '1;
    repeat (5) @(negedge clk);
    flt = '0;
    i_host.send(4'h1);
    i_host.send(4'h0);
    repeat (3) tk(tgt + step + 16'h0001);
    chk(full[21], 1'b0);
    repeat (25) @(negedge clk);
    repeat (2) tk(tgt + step + 16'h0001);
    chk(full[21], 1'b0);
    tk(tgt - step - 16'h0001);
    chk({shrt[1], full[21]}, 2'h3);
    i_host.send(4'h4);
    i_host.send(4'h0);
    @(negedge clk);
    chk({rfull[21], full[21]}, 2'h3);
    tk(tgt + step);
    chk(full[21], 1'b0);
    tk(tgt - step);
    repeat (3) tk(tgt + step + 16'h0001);
    chk(full[21], 1'b1);
    i_host.send(4'h2);
    i_host.send(4'h0);
    repeat (3) @(negedge clk);
    chk(full[21], 1'b0);
    // Rare faults and commands so that both set and clear paths get exercised
    repeat (600) begin
      r = $urandom;
      i_host.send({r[19:15] == 5'h0 && r[11:9] != 3'h0, r[11:9] == 3'h0, r[14:12] == 3'h0, r[8:6] == 3'h0});
      flt = (r[19:15] == 5'h0) ? '0 : fault_s'(r[26:20] & {7{r[27] & r[28]}});
      tick = r[29];
      spd = r[30] ? tgt + step + 16'h0001 : tgt - step;
    end
    @(negedge clk) sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    chk(full, 32'h0);
    stop_test();
  end
endmodule
